/* File: verilog/fse_regs.sv */
`timescale 1ns/1ps
module fse_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fse_pkg::fse_wb_req_type wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire fse_pkg::fse_event_type evt,
  input wire logic resetDoubleFault,
  input wire logic resetSeqDone,
  input wire logic seqStartReq,
  output logic cmdLaunch,
  output logic seqStartOk,
  output logic cmdCompleteIrq,
  output logic doubleFaultIrq,
  output logic singleFaultIrq
);
  // ==========================================================
  // bus decode
  logic access;
  logic wrStrobe;
  logic lane0;
  logic [7:0] wrByte;
  logic wrStatus;
  logic wrErrEn;
  logic wrFault;
  logic wrCfg;
  assign access = wbReq.cyc && wbReq.stb && !wbAck;
  // a write takes effect at the edge where the master samples ack high
  assign wrStrobe = wbReq.cyc && wbReq.stb && wbAck && wbReq.we;
  assign lane0 = wbReq.sel[0];
  assign wrByte = wbReq.dat[7:0];
  assign wrStatus = wrStrobe && lane0 &&
    (wbReq.adr == fse_pkg::STATUS_ADDR);
  assign wrErrEn = wrStrobe && lane0 &&
    (wbReq.adr == fse_pkg::ERR_IRQ_EN_ADDR);
  assign wrFault = wrStrobe && lane0 &&
    (wbReq.adr == fse_pkg::FAULT_FLAG_ADDR);
  assign wrCfg = wrStrobe && lane0 &&
    (wbReq.adr == fse_pkg::CFG_ADDR);

  // ==========================================================
  // status flags
  logic cmdDone_q;
  logic access_error_flag;
  logic protViol;
  logic busy_q;
  logic [1:0] cstat_q;
  logic launchReq;
  logic [1:0] flagClr;
  logic [1:0] flagSet;
  logic [1:0] accViol;

  // launch refused while an error flag is up, even in the same write
  assign launchReq = wrStatus && wrByte[fse_pkg::CMD_DONE_BIT] &&
    cmdDone_q && !access_error_flag && !protViol;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdDone_q <= fse_pkg::STATUS_RESET[fse_pkg::CMD_DONE_BIT];
    end else if (evt.cmdDone || evt.protHit ||
                 evt.seqError || evt.illegalCmd) begin
      cmdDone_q <= 1'b1;
    end else if (launchReq) begin
      cmdDone_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdLaunch <= 1'b0;
    end else begin
      cmdLaunch <= launchReq;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seqStartOk <= 1'b0;
    end else begin
      seqStartOk <= seqStartReq && !protViol;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (launchReq) begin
      busy_q <= 1'b1;
    end else if (evt.cmdDone || evt.protHit ||
                 evt.seqError || evt.illegalCmd) begin
      busy_q <= 1'b0;
    end
  end

  // completion status captured at command end or at reset sequence end with a double fault
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cstat_q <= fse_pkg::STATUS_RESET[1:0];
    end else if (resetSeqDone && resetDoubleFault) begin
      cstat_q <= 2'h3;
    end else if (evt.statusValid) begin
      cstat_q <= evt.cmdStatus;
    end else if (launchReq) begin
      cstat_q <= 2'h0;
    end
  end

  assign accViol[0] = evt.seqError || evt.illegalCmd;
  assign accViol[1] = evt.protHit;

  fse_flag uAccErr (
    .sys_clk(sys_clk),
    .rst(rst),
    .setFlag(accViol[0]),
    .clearFlag(wrStatus && wrByte[fse_pkg::ACC_ERR_BIT]),
    .flag(access_error_flag)
  );

  fse_flag uProtViol (
    .sys_clk(sys_clk),
    .rst(rst),
    .setFlag(accViol[1]),
    .clearFlag(wrStatus && wrByte[fse_pkg::PROT_VIOL_BIT]),
    .flag(protViol)
  );

  // ==========================================================
  // fault flags and enables
  logic [7:0] errEn_q;
  logic [7:0] cfg_q;
  logic [1:0] faultFlag;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      errEn_q <= fse_pkg::ERR_EN_RESET;
    end else if (wrErrEn) begin
      errEn_q <= {6'h00, wrByte[1:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= fse_pkg::CFG_RESET;
    end else if (wrCfg) begin
      cfg_q <= {wrByte[fse_pkg::CC_EN_BIT], 7'h00};
    end
  end

  assign flagSet[fse_pkg::SGL_FLAG_BIT] = evt.singleFault;
  assign flagSet[fse_pkg::DBL_FLAG_BIT] =
    evt.doubleFault || evt.busyBlockRead;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gFault
      assign flagClr[gi] = wrFault && wrByte[gi];
      fse_flag uFault (
        .sys_clk(sys_clk),
        .rst(rst),
        .setFlag(flagSet[gi]),
        .clearFlag(flagClr[gi]),
        .flag(faultFlag[gi])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt levels, registered one cycle behind flag and enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      doubleFaultIrq <= 1'b0;
      singleFaultIrq <= 1'b0;
      cmdCompleteIrq <= 1'b0;
    end else begin
      doubleFaultIrq <= faultFlag[fse_pkg::DBL_FLAG_BIT] &&
        errEn_q[fse_pkg::DBL_EN_BIT];
      singleFaultIrq <= faultFlag[fse_pkg::SGL_FLAG_BIT] &&
        errEn_q[fse_pkg::SGL_EN_BIT];
      cmdCompleteIrq <= cmdDone_q &&
        cfg_q[fse_pkg::CC_EN_BIT];
    end
  end

  // ==========================================================
  // read mux and acknowledge
  logic [7:0] statusRd;
  logic [7:0] rdByte;

  always_comb begin
    statusRd = 8'h00;
    statusRd[fse_pkg::CMD_DONE_BIT] = cmdDone_q;
    statusRd[fse_pkg::ACC_ERR_BIT] = access_error_flag;
    statusRd[fse_pkg::PROT_VIOL_BIT] = protViol;
    statusRd[fse_pkg::BUSY_BIT] = busy_q;
    statusRd[1:0] = cstat_q;
  end

  always_comb begin
    case (wbReq.adr)
      fse_pkg::STATUS_ADDR: rdByte = statusRd;
      fse_pkg::ERR_IRQ_EN_ADDR: rdByte = errEn_q;
      fse_pkg::FAULT_FLAG_ADDR: rdByte = {6'h00, faultFlag};
      fse_pkg::CFG_ADDR: rdByte = cfg_q;
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= access;
      if (access && !wbReq.we) begin
        wbDatOut <= {24'h000000, rdByte};
      end
    end
  end
endmodule

/* File: verilog/fse_pkg.sv */
// Notes on behaviour
// - double fault irq when enable bit1 set
// - single fault irq when enable bit0 set
// - error irq enable bits read/write
// - complete flag clears and launches on write-one
// - access error set on sequence/illegal command
// - access error blocks command launch
// - access error cleared only by write-one
// - violation set on protected program/erase
// - violation cleared by write-one
// - violation blocks launch and new sequence
// - busy bit reflects controller executing command
// - status bit 2 reads zero
// - completion status shows command/reset errors
// - status field access types as documented
// - reset double fault may alter status
// - double fault flag set on fault/busy read
// - fault flags cleared by write-one
// - complete irq when enable set
package fse_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  localparam logic [7:0] ERR_IRQ_EN_ADDR = 8'h1C;
  localparam logic [7:0] FAULT_FLAG_ADDR = 8'h20;
  localparam logic [7:0] CFG_ADDR = 8'h24;
  localparam logic [7:0] STATUS_INDEX = 8'h06;

  // ==========================================================
  // field positions
  localparam int CMD_DONE_BIT = 7;
  localparam int ACC_ERR_BIT = 5;
  localparam int PROT_VIOL_BIT = 4;
  localparam int BUSY_BIT = 3;
  localparam int CSTAT_LSB = 0;
  localparam int DBL_EN_BIT = 1;
  localparam int SGL_EN_BIT = 0;
  localparam int DBL_FLAG_BIT = 1;
  localparam int SGL_FLAG_BIT = 0;
  localparam int CC_EN_BIT = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [7:0] ERR_EN_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  typedef struct packed {
    logic cmdDone;
    logic seqError;
    logic illegalCmd;
    logic protHit;
    logic singleFault;
    logic doubleFault;
    logic busyBlockRead;
    logic [1:0] cmdStatus;
    logic statusValid;
  } fse_event_type;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } fse_wb_req_type;
endpackage

/* File: verilog/fse_flag.sv */
`timescale 1ns/1ps
// sticky flag: hardware set wins over software write-one clear
module fse_flag (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic setFlag,
  input wire logic clearFlag,
  output logic flag
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (setFlag) begin
      flag <= 1'b1;
    end else if (clearFlag) begin
      flag <= 1'b0;
    end
  end
endmodule

/* File: bench/fse_regs_asserts.sv */
`timescale 1ns/1ps
module fse_regs_check (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fse_pkg::fse_wb_req_type wbReq,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  input wire fse_pkg::fse_event_type evt,
  input wire logic resetDoubleFault,
  input wire logic resetSeqDone,
  input wire logic seqStartReq,
  input wire logic cmdLaunch,
  input wire logic seqStartOk,
  input wire logic cmdCompleteIrq,
  input wire logic doubleFaultIrq,
  input wire logic singleFaultIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic wr;
  assign tk = wbReq.cyc && wbReq.stb && !wbAck;
  assign wr = wbReq.cyc && wbReq.stb && wbAck && wbReq.we && wbReq.sel[0];
  a_ack_answer: assert property (tk |=> wbAck) else $error("no ack");
  a_ack_single: assert property (wbAck |=> !wbAck) else $error("ack held");
  a_launch_cause: assert property (cmdLaunch |-> $past(wr
    && wbReq.adr == fse_pkg::STATUS_ADDR && wbReq.dat[7]))
    else $error("stray launch");
  a_launch_once: assert property (cmdLaunch |=> !cmdLaunch)
    else $error("launch held");
  a_seq_gate: assert property (seqStartOk |-> $past(seqStartReq))
    else $error("stray start");
  a_viol_block: assert property (evt.protHit ##1 seqStartReq |=>
    !seqStartOk) else $error("start during violation");
  a_dbl_mask: assert property (wr && wbReq.adr ==
    fse_pkg::ERR_IRQ_EN_ADDR && !wbReq.dat[1] |-> ##2 !doubleFaultIrq)
    else $error("double irq not masked");
  a_sgl_mask: assert property (wr && wbReq.adr ==
    fse_pkg::ERR_IRQ_EN_ADDR && !wbReq.dat[0] |-> ##2 !singleFaultIrq)
    else $error("single irq not masked");
  a_cc_mask: assert property (wr && wbReq.adr == fse_pkg::CFG_ADDR
    && !wbReq.dat[7] |-> ##2 !cmdCompleteIrq) else $error("cc irq on");
  a_rsvd_zero: assert property (wbAck && $past(!wbReq.we &&
    wbReq.adr == fse_pkg::STATUS_ADDR) |-> !wbDatOut[2] &&
    wbDatOut[31:8] == 24'h000000) else $error("reserved bit set");
endmodule
bind fse_regs fse_regs_check u_chk (.sys_clk, .rst, .wbReq, .wbDatOut,
  .wbAck, .evt, .resetDoubleFault, .resetSeqDone, .seqStartReq,
  .cmdLaunch, .seqStartOk, .cmdCompleteIrq, .doubleFaultIrq,
  .singleFaultIrq);

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, rst = 1, resetDoubleFault = 0, resetSeqDone = 0;
  logic seqStartReq = 0, wbAck, cmdLaunch, seqStartOk;
  logic cmdCompleteIrq, doubleFaultIrq, singleFaultIrq;
  logic [31:0] wbDatOut;
  logic [7:0] launches = 8'h00, v, ex;
  fse_pkg::fse_wb_req_type wbReq = '0;
  fse_pkg::fse_event_type evt = '0;
  logic [7:0] expq[$];
  int errors = 0, samples_checked = 0;
  int unsigned s = 48;
  always #25 sys_clk = ~sys_clk;
  fse_regs dut (.sys_clk, .rst, .wbReq, .wbDatOut, .wbAck, .evt,
    .resetDoubleFault, .resetSeqDone, .seqStartReq, .cmdLaunch,
    .seqStartOk, .cmdCompleteIrq, .doubleFaultIrq, .singleFaultIrq);
  // ==========================================================
  // helpers
  function logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task final_report();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [7:0] e);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{adr: a, dat: {24'h000000, d}, sel: 4'hF, we: w,
      cyc: 1'b1, stb: 1'b1};
    if (!w) expq.push_back(e);
    do @(posedge sys_clk); while (wbAck !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      errors++;
      final_report();
    end
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
  endtask
  // event bits: 200 done, 100 seq, 080 illegal, 040 prot, 020 single,
  // 010 double, 008 busy read, 006 status, 001 status valid
  task ev(input logic [9:0] b);
    @(posedge sys_clk);
    evt <= b;
    @(posedge sys_clk);
    evt <= '0;
  endtask
  task seq(input logic e);
    @(posedge sys_clk);
    seqStartReq <= 1'b1;
    @(posedge sys_clk);
    seqStartReq <= 1'b0;
    #1 chk(seqStartOk, e);
  endtask
  // ==========================================================
  // read monitor and launch counter
  always @(posedge sys_clk) begin
    if (cmdLaunch === 1'b1) launches <= launches + 8'h01;
    if (wbAck === 1'b1 && wbReq.we === 1'b0 && wbReq.cyc === 1'b1) begin
      ex = expq.size() ? expq.pop_front() : 8'hEE;
      chk(wbDatOut[7:0], ex);
    end
  end
  initial begin
    #2000000 errors++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    bus(8'h18, 0, 0, 8'h80);
    bus(8'h1C, 0, 0, 8'h00);
    bus(8'h30, 0, 0, 8'h00);
    repeat (4) begin
      v = rnd();
      bus(8'h1C, 1, v, 0);
      bus(8'h1C, 0, 0, v & 8'h03);
    end
    bus(8'h1C, 1, 8'h03, 0);
    ev(10'h010);
    @(posedge sys_clk);
    #1 chk(doubleFaultIrq, 1);
    chk(singleFaultIrq, 0);
    ev(10'h020);
    @(posedge sys_clk);
    #1 chk(singleFaultIrq, 1);
    bus(8'h1C, 1, 8'h01, 0);
    @(posedge sys_clk);
    #1 chk(doubleFaultIrq, 0);
    bus(8'h20, 1, 8'h00, 0);
    bus(8'h20, 0, 0, 8'h03);
    bus(8'h20, 1, 8'h03, 0);
    bus(8'h20, 0, 0, 8'h00);
    #1 chk(singleFaultIrq, 0);
    ev(10'h008);
    bus(8'h20, 0, 0, 8'h02);
    bus(8'h24, 1, 8'h80, 0);
    @(posedge sys_clk);
    #1 chk(cmdCompleteIrq, 1);
    bus(8'h18, 1, 8'h80, 0);
    @(posedge sys_clk);
    #1 chk(cmdCompleteIrq, 0);
    chk(launches, 1);
    bus(8'h18, 0, 0, 8'h08);
    ev(10'h201);
    bus(8'h18, 0, 0, 8'h80);
    for (int i = 0; i < 2; i++) begin
      ev(i ? 10'h080 : 10'h100);
      bus(8'h18, 0, 0, 8'hA0);
      bus(8'h18, 1, 8'h80, 0);
      bus(8'h18, 1, 8'h00, 0);
      bus(8'h18, 0, 0, 8'hA0);
      bus(8'h18, 1, 8'h24, 0);
      bus(8'h18, 0, 0, 8'h80);
    end
    ev(10'h040);
    bus(8'h18, 0, 0, 8'h90);
    seq(0);
    bus(8'h18, 1, 8'h80, 0);
    bus(8'h18, 0, 0, 8'h90);
    bus(8'h18, 1, 8'h1B, 0);
    bus(8'h18, 0, 0, 8'h80);
    seq(1);
    chk(launches, 1);
    @(posedge sys_clk);
    resetDoubleFault <= 1'b1;
    resetSeqDone <= 1'b1;
    @(posedge sys_clk);
    resetSeqDone <= 1'b0;
    bus(8'h18, 0, 0, 8'h83);
    final_report();
  end
endmodule
